// *** hw/pin_mux_pkg.sv ***
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // pin group shape
  // ---------------------------------------------------------------
  localparam int NUM_PINS = 5;
  typedef logic [NUM_PINS-1:0] pin_vec_t;

  // ---------------------------------------------------------------
  // reset values and direction encoding
  // ---------------------------------------------------------------
  localparam pin_vec_t DIR_RESET = 5'h1f;
  localparam pin_vec_t LATCH_RESET = 5'h00;
  localparam pin_vec_t SYNC_RESET = 5'h00;
  localparam logic DIR_OUT = 1'h0;

  // ---------------------------------------------------------------
  // pin positions of the host port and clock functions
  // ---------------------------------------------------------------
  localparam int PIN_RD_STROBE = 0;
  localparam int PIN_WR_STROBE = 1;
  localparam int PIN_BYTE_EN = 2;
  localparam int PIN_ADDR_13 = 3;
  localparam int PIN_ADDR_12 = 4;
  localparam int PIN_REF_CLK = 3;

  // pins carrying the third pwm unit, moved by the remap bit
  localparam pin_vec_t PWM_UNIT3_MASK = 5'h18;
  // pins whose host port function is an input strobe
  localparam pin_vec_t HOST_STROBE_MASK = 5'h03;

  // ---------------------------------------------------------------
  // pin owner, highest priority has the largest code
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OWN_PORT = 3'h0,
    OWN_HOST = 3'h1,
    OWN_REF = 3'h2,
    OWN_PWM = 3'h3,
    OWN_EBUS = 3'h4
  } owner_t;

endpackage : pin_mux_pkg

// *** hw/pin_ctl_if.sv ***
`timescale 1ns/10ps
interface pin_ctl_if;
  pin_mux_pkg::pin_vec_t dir;
  pin_mux_pkg::pin_vec_t latch;
  pin_mux_pkg::pin_vec_t level;

  modport regs (output dir, output latch, output level);
  modport mux (input dir, input latch, input level);
endinterface : pin_ctl_if

// *** hw/port_regs.sv ***
`timescale 1ns/10ps
module port_regs (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic dir_wr_en, // direction write strobe
  input wire logic level_wr_en, // port register write strobe
  input wire logic latch_wr_en, // latch register write strobe
  input wire pin_mux_pkg::pin_vec_t wr_data, // write data
  input wire pin_mux_pkg::pin_vec_t pin_in, // raw pin levels
  pin_ctl_if.regs ctl // register state out
);

  pin_mux_pkg::pin_vec_t dir_r;
  pin_mux_pkg::pin_vec_t dir_nxt;
  pin_mux_pkg::pin_vec_t latch_r;
  pin_mux_pkg::pin_vec_t latch_nxt;
  pin_mux_pkg::pin_vec_t sync1_r;
  pin_mux_pkg::pin_vec_t sync1_nxt;
  pin_mux_pkg::pin_vec_t sync2_r;
  pin_mux_pkg::pin_vec_t sync2_nxt;

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------
  always_comb
  begin
    dir_nxt = dir_wr_en ? wr_data : dir_r;
    // both register addresses land in the same latches
    latch_nxt = (level_wr_en || latch_wr_en) ? wr_data : latch_r; // [R2]
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dir_r <= pin_mux_pkg::DIR_RESET;
      latch_r <= pin_mux_pkg::LATCH_RESET;
      sync1_r <= pin_mux_pkg::SYNC_RESET;
      sync2_r <= pin_mux_pkg::SYNC_RESET;
    end
    else
    begin
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign ctl.dir = dir_r;
  assign ctl.latch = latch_r;
  assign ctl.level = sync2_r; // [R17]

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_latch_write;
    (level_wr_en || latch_wr_en) |=> (latch_r == $past(wr_data));
  endproperty
  a_latch_write: assert property (p_latch_write) // [R2]
    else $error("latch not loaded by port or latch write");

  property p_level_sync;
    ##2 1'b1 |-> (sync2_r == $past(pin_in, 2));
  endproperty
  a_level_sync: assert property (p_level_sync) // [R17]
    else $error("pin level not two cycles behind pin");

endmodule : port_regs

// *** hw/port_e_low_pin_function_mux.sv ***
// How it works
// [R1] a direction bit of 0 drives the pin from its latch, 1 makes it input.
// [R2] a write to the port register or the latch register loads the latches.
// [R3] with the memory bus active, pins 0-4 are its address/data bits 8-12.
// [R4] the memory bus samples pins 0-4 as its data bits 8-12 when reading.
// [R5] the host port read strobe leaves on pin 0 whatever its direction.
// [R6] the host port write strobe leaves on pin 1 whatever its direction.
// [R7] pins 0 and 1 also feed read and write strobes in to the host port.
// [R8] the host port byte enable leaves on pin 2 whatever its direction.
// [R9] host port address 13 leaves on pin 3 and address 12 on pin 4.
// [R10] an enabled pwm channel with direction 0 beats latch and host data.
// [R11] pwm pins can be floated while a pwm shutdown is in effect.
// [R12] on 80-pin parts the third pwm unit sits here only when remapped.
// [R13] the memory bus beats every other function on these pins.
// [R14] pins go to port and peripherals only while the bus is disabled.
// [R15] the host port uses these pins only when its remap bit is 1.
// [R16] pin 3 can output the reference clock whatever its direction.
// [R17] reads of the port register give the sampled pin level.
`timescale 1ns/10ps
module port_e_low_pin_function_mux #(
  parameter int PIN_COUNT = 5, // pins served by this block
  parameter bit IS_80_PIN = 1'b1 // package has the memory bus
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous reset, active high
  input wire logic dir_wr_en, // pin_direction_reg write strobe
  input wire logic level_wr_en, // pin_level_reg write strobe
  input wire logic latch_wr_en, // latch register write strobe
  input wire pin_mux_pkg::pin_vec_t wr_data, // register write data
  output pin_mux_pkg::pin_vec_t pin_direction_reg, // direction readback
  output pin_mux_pkg::pin_vec_t latch_reg, // latch readback
  output pin_mux_pkg::pin_vec_t pin_level_reg, // sampled pin levels
  input wire logic ext_bus_disable, // memory_control_reg bit 7
  input wire pin_mux_pkg::pin_vec_t ext_bus_ad_out, // bus ad 12:8 out
  input wire logic ext_bus_ad_oe, // bus drives ad lines
  output pin_mux_pkg::pin_vec_t ext_bus_ad_in, // bus data 12:8 in
  input wire logic host_port_remap_cfg, // host port on these pins
  input wire logic host_port_en, // host port enabled
  input wire logic host_strobe_oe, // host port drives its strobes
  input wire logic host_port_read_strobe, // read strobe out
  input wire logic host_port_write_strobe, // write strobe out
  input wire logic host_port_byte_enable, // byte enable out
  input wire logic host_port_addr_13, // address line 13 out
  input wire logic host_port_addr_12, // address line 12 out
  output logic host_read_strobe_in, // read strobe from pin 0
  output logic host_write_strobe_in, // write strobe from pin 1
  input wire pin_mux_pkg::pin_vec_t pwm_chan_out, // pwm levels per pin
  input wire pin_mux_pkg::pin_vec_t pwm_chan_en, // pwm channel enables
  input wire logic pwm_shutdown, // pwm shutdown in effect
  input wire logic pwm_shutdown_float, // float pwm pins on shutdown
  input wire logic pwm_remap_cfg, // third pwm unit on pins 4:3
  input wire logic ref_clock_en, // reference clock on pin 3
  input wire logic ref_clock_out, // reference clock level
  input wire pin_mux_pkg::pin_vec_t pin_in, // pin input levels
  output pin_mux_pkg::pin_vec_t pin_out, // pin output levels
  output pin_mux_pkg::pin_vec_t pin_oe // pin output enables
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (PIN_COUNT != pin_mux_pkg::NUM_PINS)
  begin : g_bad_count
    $error("pin count must be 5");
  end

  // ---------------------------------------------------------------
  // register file and input synchroniser
  // ---------------------------------------------------------------
  pin_ctl_if ctl ();

  port_regs u_regs (
    .core_clk (core_clk),
    .reset (reset),
    .dir_wr_en (dir_wr_en),
    .level_wr_en (level_wr_en),
    .latch_wr_en (latch_wr_en),
    .wr_data (wr_data),
    .pin_in (pin_in),
    .ctl (ctl.regs)
  );

  assign pin_direction_reg = ctl.dir;
  assign latch_reg = ctl.latch;
  assign pin_level_reg = ctl.level; // [R17]

  // ---------------------------------------------------------------
  // owner selection
  // ---------------------------------------------------------------
  function automatic pin_mux_pkg::owner_t pick_owner(
    input logic ebus,
    input logic pwm,
    input logic refc,
    input logic host
  );
    pin_mux_pkg::owner_t own;
    own = pin_mux_pkg::OWN_PORT;
    if (ebus)
      own = pin_mux_pkg::OWN_EBUS; // [R13]
    else if (pwm)
      own = pin_mux_pkg::OWN_PWM; // [R10]
    else if (refc)
      own = pin_mux_pkg::OWN_REF;
    else if (host)
      own = pin_mux_pkg::OWN_HOST;
    return own;
  endfunction : pick_owner

  logic ebus_active;
  logic host_active;
  logic pwm_float;
  pin_mux_pkg::pin_vec_t pwm_map_ok;
  pin_mux_pkg::pin_vec_t pwm_ok;
  pin_mux_pkg::pin_vec_t ref_ok;
  pin_mux_pkg::pin_vec_t host_val;
  pin_mux_pkg::pin_vec_t host_oe;
  pin_mux_pkg::owner_t owner [pin_mux_pkg::NUM_PINS];

  // the bus exists only on the larger package
  assign ebus_active = IS_80_PIN && !ext_bus_disable; // [R14]
  assign host_active = host_port_en && host_port_remap_cfg; // [R15]
  assign pwm_float = pwm_shutdown && pwm_shutdown_float; // [R11]

  always_comb
  begin
    // third unit moves away on the larger package unless remapped
    pwm_map_ok = '1;
    if (IS_80_PIN && !pwm_remap_cfg)
      pwm_map_ok = ~pin_mux_pkg::PWM_UNIT3_MASK; // [R12]
    // pwm channels need the direction bit at output
    pwm_ok = pwm_chan_en & pwm_map_ok & ~ctl.dir; // [R10]
    ref_ok = '0;
    ref_ok[pin_mux_pkg::PIN_REF_CLK] = ref_clock_en; // [R16]
    host_val = '0;
    host_val[pin_mux_pkg::PIN_RD_STROBE] = host_port_read_strobe; // [R5]
    host_val[pin_mux_pkg::PIN_WR_STROBE] = host_port_write_strobe; // [R6]
    host_val[pin_mux_pkg::PIN_BYTE_EN] = host_port_byte_enable; // [R8]
    host_val[pin_mux_pkg::PIN_ADDR_13] = host_port_addr_13; // [R9]
    host_val[pin_mux_pkg::PIN_ADDR_12] = host_port_addr_12; // [R9]
    // strobes turn round when an outside party drives them
    host_oe = ~pin_mux_pkg::HOST_STROBE_MASK;
    if (host_strobe_oe)
      host_oe = '1; // [R7]
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++)
      owner[i] = pick_owner(ebus_active, pwm_ok[i], ref_ok[i], host_active);
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  pin_mux_pkg::pin_vec_t out_r;
  pin_mux_pkg::pin_vec_t out_nxt;
  pin_mux_pkg::pin_vec_t oe_r;
  pin_mux_pkg::pin_vec_t oe_nxt;

  always_comb
  begin
    out_nxt = '0;
    oe_nxt = '0;
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++)
    begin
      case (owner[i])
        pin_mux_pkg::OWN_EBUS:
        begin
          out_nxt[i] = ext_bus_ad_out[i]; // [R3]
          oe_nxt[i] = ext_bus_ad_oe; // [R3]
        end
        pin_mux_pkg::OWN_PWM:
        begin
          out_nxt[i] = pwm_chan_out[i]; // [R10]
          oe_nxt[i] = !pwm_float; // [R11]
        end
        pin_mux_pkg::OWN_REF:
        begin
          out_nxt[i] = ref_clock_out; // [R16]
          oe_nxt[i] = 1'b1; // [R16]
        end
        pin_mux_pkg::OWN_HOST:
        begin
          out_nxt[i] = host_val[i];
          oe_nxt[i] = host_oe[i];
        end
        pin_mux_pkg::OWN_PORT:
        begin
          out_nxt[i] = ctl.latch[i]; // [R1]
          oe_nxt[i] = (ctl.dir[i] == pin_mux_pkg::DIR_OUT); // [R1]
        end
        default:
        begin
          out_nxt[i] = 1'b0;
          oe_nxt[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      out_r <= '0;
      oe_r <= '0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe = oe_r;

  // ---------------------------------------------------------------
  // input paths to the memory bus and host port
  // ---------------------------------------------------------------
  pin_mux_pkg::pin_vec_t ad_in_r;
  pin_mux_pkg::pin_vec_t ad_in_nxt;
  logic rd_in_r;
  logic rd_in_nxt;
  logic wr_in_r;
  logic wr_in_nxt;

  always_comb
  begin
    ad_in_nxt = ad_in_r;
    // follow the pins while the bus reads, hold while it drives
    if (ebus_active && !ext_bus_ad_oe)
      ad_in_nxt = ctl.level; // [R4]
    rd_in_nxt = ctl.level[pin_mux_pkg::PIN_RD_STROBE]; // [R7]
    wr_in_nxt = ctl.level[pin_mux_pkg::PIN_WR_STROBE]; // [R7]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ad_in_r <= '0;
      rd_in_r <= 1'b0;
      wr_in_r <= 1'b0;
    end
    else
    begin
      ad_in_r <= ad_in_nxt;
      rd_in_r <= rd_in_nxt;
      wr_in_r <= wr_in_nxt;
    end
  end

  assign ext_bus_ad_in = ad_in_r;
  assign host_read_strobe_in = rd_in_r;
  assign host_write_strobe_in = wr_in_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic quiet;
  assign quiet = ext_bus_disable && !host_active && pwm_chan_en == '0
    && !ref_clock_en;

  property p_port_dir;
    quiet |=> pin_oe == ~$past(ctl.dir) && pin_out == $past(ctl.latch);
  endproperty
  a_port_dir: assert property (p_port_dir) // [R1]
    else $error("idle pins do not follow direction and latch");

  sequence s_bus_drive;
    ebus_active && ext_bus_ad_oe;
  endsequence
  property p_bus_drive;
    s_bus_drive |=> pin_oe == '1 && pin_out == $past(ext_bus_ad_out);
  endproperty
  a_bus_drive: assert property (p_bus_drive) // [R3]
    else $error("memory bus does not own pins while active");

  property p_bus_read;
    (ebus_active && !ext_bus_ad_oe) |=> ext_bus_ad_in == $past(ctl.level);
  endproperty
  a_bus_read: assert property (p_bus_read) // [R4]
    else $error("memory bus read data not sampled from pins");

  property p_bus_first;
    (ebus_active && !ext_bus_ad_oe) |=> pin_oe == '0;
  endproperty
  a_bus_first: assert property (p_bus_first) // [R13]
    else $error("other function drives pins under the memory bus");

  property p_host_strobe;
    (ext_bus_disable && host_active && host_strobe_oe && !ref_clock_en
      && pwm_chan_en == '0) |=> pin_oe == '1
      && pin_out[0] == $past(host_port_read_strobe)
      && pin_out[1] == $past(host_port_write_strobe)
      && pin_out[2] == $past(host_port_byte_enable)
      && pin_out[3] == $past(host_port_addr_13)
      && pin_out[4] == $past(host_port_addr_12);
  endproperty
  a_host_strobe: assert property (p_host_strobe) // [R5]
    else $error("host port outputs not on their pins");

  property p_strobe_in;
    ##1 1'b1 |-> host_read_strobe_in == $past(ctl.level[0])
      && host_write_strobe_in == $past(ctl.level[1]);
  endproperty
  a_strobe_in: assert property (p_strobe_in) // [R7]
    else $error("host strobe inputs not taken from pins");

  property p_pwm_wins;
    (ext_bus_disable && pwm_ok[0] && !pwm_float)
      |=> pin_oe[0] && pin_out[0] == $past(pwm_chan_out[0]);
  endproperty
  a_pwm_wins: assert property (p_pwm_wins) // [R10]
    else $error("pwm channel does not override pin 0");

  property p_pwm_float;
    (ext_bus_disable && pwm_float) |=> (pin_oe & $past(pwm_ok)) == '0;
  endproperty
  a_pwm_float: assert property (p_pwm_float) // [R11]
    else $error("pwm pin driven during floating shutdown");

  property p_remap;
    (ext_bus_disable && IS_80_PIN && !pwm_remap_cfg && host_active) |=>
      pin_oe[4] && pin_out[4] == $past(host_port_addr_12);
  endproperty
  a_remap: assert property (p_remap) // [R12]
    else $error("third pwm unit on pins without remap");

  property p_host_off;
    (quiet || !host_port_remap_cfg) && ext_bus_disable && pwm_chan_en == '0
      && !ref_clock_en |=> pin_oe == ~$past(ctl.dir);
  endproperty
  a_host_off: assert property (p_host_off) // [R15]
    else $error("host port on pins with remap bit clear");

  property p_ref_clk;
    (ext_bus_disable && ref_clock_en && !pwm_ok[3])
      |=> pin_oe[3] && pin_out[3] == $past(ref_clock_out);
  endproperty
  a_ref_clk: assert property (p_ref_clk) // [R16]
    else $error("reference clock missing on pin 3");

endmodule : port_e_low_pin_function_mux

// *** dv/pad_world.sv ***
`timescale 1ns/10ps
module pad_world (
  input wire logic core_clk, // core clock
  input wire pin_mux_pkg::pin_vec_t pin_out, // device drive levels
  input wire pin_mux_pkg::pin_vec_t pin_oe, // device drive enables
  input wire pin_mux_pkg::pin_vec_t ext_val, // outside drive levels
  input wire pin_mux_pkg::pin_vec_t ext_en, // outside drive enables
  output pin_mux_pkg::pin_vec_t pin_in // resolved pad levels
);
  // ---------------------------------------------------------------
  // undriven pads toggle so a stale level never passes for a driven one
  // ---------------------------------------------------------------
  pin_mux_pkg::pin_vec_t float_r = 5'h0a;

  always_ff @(posedge core_clk)
  begin
    float_r <= ~float_r;
  end

  always_comb
  begin
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = float_r[i];
    end
  end
endmodule : pad_world

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic dir_wr_en = 1'b0, level_wr_en = 1'b0, latch_wr_en = 1'b0;
  logic ebus_dis = 1'b1, ad_oe = 1'b0, remap = 1'b1, host_en = 1'b0;
  logic sb_oe = 1'b1, rd = 1'b0, wr = 1'b0, be = 1'b0, a13 = 1'b0;
  logic a12 = 1'b0, sd = 1'b0, sd_float = 1'b0, pwm_remap = 1'b1;
  logic ref_en = 1'b0, ref_out = 1'b0, rd_in, wr_in;
  pin_mux_pkg::pin_vec_t wr_data = 5'h00, ad_out = 5'h00;
  pin_mux_pkg::pin_vec_t pwm_out = 5'h00, pwm_en = 5'h00;
  pin_mux_pkg::pin_vec_t ext_val = 5'h00, ext_en = 5'h00;
  pin_mux_pkg::pin_vec_t dir_q, latch_q, level_q, ad_in;
  pin_mux_pkg::pin_vec_t pin_in, pin_out, pin_oe;
  int error_cnt = 0;
  int n_compared = 0;

  always #25 core_clk = ~core_clk;

  port_e_low_pin_function_mux #(.PIN_COUNT(5), .IS_80_PIN(1'b1)) DUT (
    .core_clk(core_clk), .reset(reset), .dir_wr_en(dir_wr_en),
    .level_wr_en(level_wr_en), .latch_wr_en(latch_wr_en),
    .wr_data(wr_data), .pin_direction_reg(dir_q), .latch_reg(latch_q),
    .pin_level_reg(level_q), .ext_bus_disable(ebus_dis),
    .ext_bus_ad_out(ad_out), .ext_bus_ad_oe(ad_oe), .ext_bus_ad_in(ad_in),
    .host_port_remap_cfg(remap), .host_port_en(host_en),
    .host_strobe_oe(sb_oe), .host_port_read_strobe(rd),
    .host_port_write_strobe(wr), .host_port_byte_enable(be),
    .host_port_addr_13(a13), .host_port_addr_12(a12),
    .host_read_strobe_in(rd_in), .host_write_strobe_in(wr_in),
    .pwm_chan_out(pwm_out), .pwm_chan_en(pwm_en), .pwm_shutdown(sd),
    .pwm_shutdown_float(sd_float), .pwm_remap_cfg(pwm_remap),
    .ref_clock_en(ref_en), .ref_clock_out(ref_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));

  pad_world pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic chk(input pin_mux_pkg::pin_vec_t got,
                     input pin_mux_pkg::pin_vec_t exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // sel 0 direction, 1 port register, 2 latch register
  task automatic write_reg(input int sel, input pin_mux_pkg::pin_vec_t v);
    wr_data = v;
    dir_wr_en = (sel == 0);
    level_wr_en = (sel == 1);
    latch_wr_en = (sel == 2);
    step(1);
    dir_wr_en = 1'b0;
    level_wr_en = 1'b0;
    latch_wr_en = 1'b0;
    step(1);
  endtask : write_reg

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    chk(dir_q, 5'h1f, "reset direction");
    chk(latch_q, 5'h00, "reset latch");
    chk(pin_oe, 5'h00, "reset drive");
    chk(pin_out, 5'h00, "reset drive level");
    chk(ad_in, 5'h00, "reset bus data");
  endtask : test_reset

  task automatic test_port();
    write_reg(2, 5'h1f);
    write_reg(0, 5'h03);
    step(1);
    chk(pin_oe, 5'h1c, "port direction");
    chk(pin_out & 5'h1c, 5'h1c, "port latch drive");
    ext_val = 5'h02;
    ext_en = 5'h03;
    step(3);
    chk(level_q, 5'h1e, "pin level read");
    write_reg(1, 5'h00);
    chk(latch_q, 5'h00, "port write clears latch");
    step(1);
    chk(pin_out & 5'h1c, 5'h00, "cleared drive");
    write_reg(2, 5'h14);
    chk(latch_q, 5'h14, "latch write");
    write_reg(2, 5'h00);
    chk(latch_q, 5'h00, "latch clear");
    ext_en = 5'h00;
  endtask : test_port

  task automatic test_ebus();
    write_reg(0, 5'h00);
    pwm_en = 5'h1f;
    pwm_out = 5'h1f;
    host_en = 1'b1;
    ref_en = 1'b1;
    ebus_dis = 1'b0;
    ad_out = 5'h09;
    ad_oe = 1'b1;
    step(2);
    chk(pin_out, 5'h09, "bus drive");
    chk(pin_oe, 5'h1f, "bus drive enable");
    ad_oe = 1'b0;
    ext_val = 5'h16;
    ext_en = 5'h1f;
    step(4);
    chk(pin_oe, 5'h00, "bus read release");
    chk(ad_in, 5'h16, "bus read data");
    ebus_dis = 1'b1;
    ext_en = 5'h00;
    step(4);
    chk(ad_in, 5'h16, "bus data hold");
    chk(pin_oe, 5'h1f, "pins released");
    chk(pin_out, 5'h1f, "pins released to pwm");
    pwm_en = 5'h00;
    host_en = 1'b0;
    ref_en = 1'b0;
    write_reg(0, 5'h1f);
  endtask : test_ebus

  task automatic test_host();
    host_en = 1'b1;
    {a12, a13, be, wr, rd} = 5'h15;
    step(2);
    chk(pin_out, 5'h15, "host outputs");
    chk(pin_oe, 5'h1f, "host enables");
    {a12, a13, be, wr, rd} = 5'h0a;
    step(2);
    chk(pin_out, 5'h0a, "host outputs flipped");
    sb_oe = 1'b0;
    ext_val = 5'h01;
    ext_en = 5'h03;
    step(4);
    chk(pin_oe, 5'h1c, "strobe pins input");
    chk({3'h0, wr_in, rd_in}, 5'h01, "read strobe in");
    ext_val = 5'h02;
    step(4);
    chk({3'h0, wr_in, rd_in}, 5'h02, "write strobe in");
    ext_en = 5'h00;
    sb_oe = 1'b1;
    remap = 1'b0;
    step(2);
    chk(pin_oe, 5'h00, "host unmapped");
    remap = 1'b1;
    host_en = 1'b0;
  endtask : test_host

  task automatic test_pwm();
    write_reg(0, 5'h00);
    host_en = 1'b1;
    {a12, a13, be, wr, rd} = 5'h1f;
    pwm_en = 5'h1f;
    pwm_out = 5'h05;
    step(2);
    chk(pin_out, 5'h05, "pwm over host");
    chk(pin_oe, 5'h1f, "pwm enables");
    pwm_remap = 1'b0;
    step(2);
    chk(pin_out, 5'h1d, "unit3 not mapped");
    pwm_remap = 1'b1;
    pwm_en = 5'h0a;
    pwm_out = 5'h00;
    step(2);
    chk(pin_out, 5'h15, "per channel enable");
    write_reg(0, 5'h02);
    step(1);
    chk(pin_out, 5'h17, "pwm needs output direction");
    sd = 1'b1;
    step(2);
    chk(pin_oe, 5'h1f, "shutdown without float");
    sd_float = 1'b1;
    step(2);
    chk(pin_oe, 5'h17, "shutdown float");
    sd = 1'b0;
    sd_float = 1'b0;
    pwm_en = 5'h00;
    host_en = 1'b0;
  endtask : test_pwm

  task automatic test_ref();
    write_reg(0, 5'h1f);
    ref_en = 1'b1;
    ref_out = 1'b1;
    step(2);
    chk(pin_oe, 5'h08, "ref clock enable");
    chk(pin_out & 5'h08, 5'h08, "ref clock high");
    ref_out = 1'b0;
    step(2);
    chk(pin_out & 5'h08, 5'h00, "ref clock low");
    ref_en = 1'b0;
  endtask : test_ref

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    step(1);
    test_reset();
    test_port();
    test_ebus();
    test_host();
    test_pwm();
    test_ref();
    summarize();
  end

  initial
  begin
    #(50 * 2000);
    error_cnt++;
    summarize();
  end
endmodule : testbench
